// ### opt_pkg.sv
package opt_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses on the wishbone bus)
  // ------------------------------------------------------------
  localparam int ADDR_W = 5; // byte address width seen by the channel
  localparam logic [4:0] OFS_MODE = 5'h00; // mode and pin configuration
  localparam logic [4:0] OFS_TIMER = 5'h04; // timer register, write side feeds reload
  localparam logic [4:0] OFS_START = 5'h08; // count start flag
  localparam logic [4:0] OFS_ONESHOT = 5'h0C; // one-shot start flag, write-only strobe
  localparam logic [4:0] OFS_STATUS = 5'h10; // read-only live state

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int MODE_LSB = 0; // operating mode, two bits
  localparam int CKS_LSB = 2; // count clock select, two bits
  localparam int PWM8_BIT = 4; // 1: 8-bit modulator, 0: 16-bit
  localparam int PULSE_OUT_BIT = 5; // 1: pin shows timer pulse, 0: port bit outside modulation
  localparam int PORT_BIT = 6; // port data when pin acts as a port
  localparam int TRIG_SEL_BIT = 7; // 1: other timer overflow is a trigger
  localparam int START_BIT = 0; // count start flag / one-shot strobe
  localparam int STAT_RUN_BIT = 0; // status: channel is counting
  localparam int STAT_PULSE_BIT = 1; // status: pulse level

  // ------------------------------------------------------------
  // enumerations
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_TIMER = 2'h0,
    MODE_EVENT = 2'h1,
    MODE_ONESHOT = 2'h2,
    MODE_PWM = 2'h3
  } opt_mode_t;

  typedef enum logic [1:0] {
    CKS_F1 = 2'h0,
    CKS_F8 = 2'h1,
    CKS_F32 = 2'h2,
    CKS_RSVD = 2'h3
  } opt_cks_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ONESHOT = 3'b010,
    ST_PWM = 3'b100
  } opt_st_t;

  // ------------------------------------------------------------
  // counts and reset values
  // ------------------------------------------------------------
  localparam int DIV8 = 8; // divider for the div8 count clock
  localparam int DIV32 = 32; // divider for the div32 count clock
  localparam logic [15:0] PWM16_TOP = 16'hFFFE; // last step of a 2^16-1 cycle
  localparam logic [15:0] PWM8_TOP = 16'h00FE; // last step of a 2^8-1 cycle
  localparam logic [15:0] TIMER_UNDEF = 16'hFFFF; // value returned on timer reads
  localparam logic [15:0] RELOAD_RST = 16'h0000; // reload and counter after reset
  localparam int MAX_CHANNEL = 4; // channels are numbered 0 to 4
  localparam int PWM_CH_A = 2; // channels with a pulse pin
  localparam int PWM_CH_B = 3;

endpackage

// ### opt_reg_if.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// register access carrier between bus slave and channel
// ------------------------------------------------------------
interface opt_reg_if;
  logic wr; // one-cycle write strobe
  logic [opt_pkg::ADDR_W-1:0] addr; // byte address of the access
  logic [31:0] wdata; // write data
  logic [3:0] sel; // byte enables
  logic [31:0] rdata; // read data for addr, combinational

  modport bus (output wr, output addr, output wdata, output sel, input rdata);
  modport regs (input wr, input addr, input wdata, input sel, output rdata);
endinterface

// ### opt_prescaler.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// count clock prescaler: one tick per selected count period
// ------------------------------------------------------------
module opt_prescaler #(
  parameter int DIV_W = 5
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire opt_pkg::opt_cks_t cks_i,
  output logic tick_o
);

  // the free counter must span the largest divider exactly
  if ((1 << DIV_W) != opt_pkg::DIV32) begin : g_bad_div
    $error("opt_prescaler: DIV_W does not match the div32 divider");
  end

  typedef struct packed {
    logic [DIV_W-1:0] div; // free-running divider
  } opt_pre_st_t;

  opt_pre_st_t q_ff;
  opt_pre_st_t nxt_q;

  localparam logic [DIV_W-1:0] LAST8 = DIV_W'(opt_pkg::DIV8 - 1);
  localparam logic [DIV_W-1:0] LAST32 = DIV_W'(opt_pkg::DIV32 - 1);

  // select the tick; the reserved code falls back to div32 so a bad
  // setting only slows the channel instead of stopping it
  always_comb begin
    nxt_q = q_ff;
    nxt_q.div = q_ff.div + 1'b1;
    unique case (cks_i)
      opt_pkg::CKS_F1: tick_o = ce_i;
      opt_pkg::CKS_F8: tick_o = ce_i && ((q_ff.div & LAST8) == LAST8);
      default: tick_o = ce_i && (q_ff.div == LAST32);
    endcase
  end

  // divider register, frozen while the clock enable is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_ff <= '0;
    end else if (ce_i) begin
      q_ff <= nxt_q;
    end
  end

endmodule

// ### opt_wb_slave.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// classic wishbone slave, one wait state, always acknowledges
// ------------------------------------------------------------
module opt_wb_slave (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [opt_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  opt_reg_if.bus regs
);

  typedef struct packed {
    logic ack; // acknowledge, high for one cycle
    logic [31:0] rdata; // captured read data
  } opt_wb_st_t;

  opt_wb_st_t q_ff;
  opt_wb_st_t nxt_q;

  logic req; // a request is pending and not yet answered

  // the write lands on the edge where ack is high, the same edge at
  // which the master sees the answer, so no write happens twice
  always_comb begin
    req = wb_cyc_i && wb_stb_i && !q_ff.ack;
    nxt_q = q_ff;
    nxt_q.ack = req;
    if (req) begin
      nxt_q.rdata = regs.rdata;
    end
    regs.wr = wb_cyc_i && wb_stb_i && wb_we_i && q_ff.ack && ce_i;
    regs.addr = wb_adr_i;
    regs.wdata = wb_dat_i;
    regs.sel = wb_sel_i;
    wb_ack_o = q_ff.ack;
    wb_dat_o = q_ff.rdata;
  end

  // bus state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_ff <= '0;
    end else if (ce_i) begin
      q_ff <= nxt_q;
    end
  end

endmodule

// ### opt_timer_channel.sv
`timescale 1ns/10ps
module opt_timer_channel #(
  parameter int CHANNEL_ID = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [opt_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic trig_ovf_i,
  output logic channel_pulse_pin_o,
  output logic irq_req_o
);

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  if (CHANNEL_ID < 0 || CHANNEL_ID > opt_pkg::MAX_CHANNEL) begin : g_bad_ch
    $error("opt_timer_channel: CHANNEL_ID out of range");
  end

  // only the channels with a pulse pin can modulate
  localparam bit PWM_OK = (CHANNEL_ID == opt_pkg::PWM_CH_A) ||
                          (CHANNEL_ID == opt_pkg::PWM_CH_B);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    opt_pkg::opt_mode_t mode; // selected operating mode
    opt_pkg::opt_cks_t cks; // count clock select
    logic pwm8; // 8-bit modulator select
    logic pulse_out; // pin shows pulse instead of port bit
    logic port_bit; // port data for the pin
    logic trig_sel; // other timer overflow acts as trigger
    logic start; // count start flag
    logic [15:0] reload; // reload register
    logic [15:0] cnt; // counter; in modulation holds latched n/m
    logic [7:0] sub; // modulation prescale, counts 0..m
    logic [15:0] cyc; // modulation step within the cycle
    logic pulse; // internal pulse level
    logic irq; // interrupt request, one cycle
    logic pin; // registered pin level
    opt_pkg::opt_st_t st; // channel state
  } opt_ch_st_t;

  opt_ch_st_t q_ff; // current state
  opt_ch_st_t nxt_q; // next state

  opt_reg_if rif (); // bus slave to register file
  logic tick; // one pulse per selected count period

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // address match, used by both the write and the read decode
  function automatic logic hit(input logic [opt_pkg::ADDR_W-1:0] a,
                               input logic [4:0] ofs);
    hit = (a == ofs);
  endfunction

  // merge two byte lanes of a write into a 16-bit value
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    merge16 = r;
  endfunction

  // ------------------------------------------------------------
  // submodules
  // ------------------------------------------------------------
  opt_wb_slave u_bus (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .regs(rif.bus)
  );

  // count clock is div1, div8 or div32 of clk_i
  opt_prescaler #(
    .DIV_W(5)
  ) u_pre (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .cks_i(q_ff.cks),
    .tick_o(tick)
  );

  // ------------------------------------------------------------
  // read decode
  // ------------------------------------------------------------
  // the live count is never exposed on reads of the timer register
  always_comb begin
    rif.rdata = 32'h0000_0000;
    if (hit(rif.addr, opt_pkg::OFS_MODE)) begin
      rif.rdata[opt_pkg::MODE_LSB +: 2] = q_ff.mode;
      rif.rdata[opt_pkg::CKS_LSB +: 2] = q_ff.cks;
      rif.rdata[opt_pkg::PWM8_BIT] = q_ff.pwm8;
      rif.rdata[opt_pkg::PULSE_OUT_BIT] = q_ff.pulse_out;
      rif.rdata[opt_pkg::PORT_BIT] = q_ff.port_bit;
      rif.rdata[opt_pkg::TRIG_SEL_BIT] = q_ff.trig_sel;
    end else if (hit(rif.addr, opt_pkg::OFS_TIMER)) begin
      rif.rdata[15:0] = opt_pkg::TIMER_UNDEF;
    end else if (hit(rif.addr, opt_pkg::OFS_START)) begin
      rif.rdata[opt_pkg::START_BIT] = q_ff.start;
    end else if (hit(rif.addr, opt_pkg::OFS_STATUS)) begin
      rif.rdata[opt_pkg::STAT_RUN_BIT] = (q_ff.st != opt_pkg::ST_IDLE);
      rif.rdata[opt_pkg::STAT_PULSE_BIT] = q_ff.pulse;
    end
  end

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  logic os_req; // one-shot start flag written with 1
  logic trigger; // one-shot trigger from software or other timer
  logic [15:0] wr_val; // timer register value after a write
  logic [15:0] n_cur; // high-phase length in steps
  logic [7:0] m_cur; // count periods per step minus one
  logic [15:0] top; // last step of a modulation cycle
  logic [15:0] cyc_nx; // next modulation step
  logic [15:0] n_new; // high-phase length of the reloaded value

  always_comb begin
    nxt_q = q_ff;
    nxt_q.irq = 1'b0;
    os_req = 1'b0;
    wr_val = merge16(q_ff.reload, rif.wdata, rif.sel);

    // register writes
    if (rif.wr && hit(rif.addr, opt_pkg::OFS_MODE) && rif.sel[0]) begin
      nxt_q.mode = opt_pkg::opt_mode_t'(rif.wdata[opt_pkg::MODE_LSB +: 2]);
      nxt_q.cks = opt_pkg::opt_cks_t'(rif.wdata[opt_pkg::CKS_LSB +: 2]);
      nxt_q.pwm8 = rif.wdata[opt_pkg::PWM8_BIT];
      nxt_q.pulse_out = rif.wdata[opt_pkg::PULSE_OUT_BIT];
      nxt_q.port_bit = rif.wdata[opt_pkg::PORT_BIT];
      nxt_q.trig_sel = rif.wdata[opt_pkg::TRIG_SEL_BIT];
    end
    if (rif.wr && hit(rif.addr, opt_pkg::OFS_TIMER)) begin
      nxt_q.reload = wr_val;
      if (!q_ff.start) begin
        nxt_q.cnt = wr_val;
      end
    end
    if (rif.wr && hit(rif.addr, opt_pkg::OFS_START) && rif.sel[0]) begin
      nxt_q.start = rif.wdata[opt_pkg::START_BIT];
    end
    if (rif.wr && hit(rif.addr, opt_pkg::OFS_ONESHOT) && rif.sel[0]) begin
      os_req = rif.wdata[opt_pkg::START_BIT];
    end

    // trigger sources for a one-shot pass
    trigger = os_req || (q_ff.trig_sel && trig_ovf_i);

    // modulation geometry of the latched value
    n_cur = q_ff.pwm8 ? {8'h00, q_ff.cnt[15:8]} : q_ff.cnt;
    m_cur = q_ff.pwm8 ? q_ff.cnt[7:0] : 8'h00;
    top = q_ff.pwm8 ? opt_pkg::PWM8_TOP : opt_pkg::PWM16_TOP;
    cyc_nx = (q_ff.cyc == top) ? 16'h0000 : q_ff.cyc + 16'h0001;
    n_new = q_ff.pwm8 ? {8'h00, q_ff.reload[15:8]} : q_ff.reload;

    unique case (q_ff.st)
      // waiting for a start condition
      opt_pkg::ST_IDLE: begin
        nxt_q.pulse = 1'b0;
        if (q_ff.start && q_ff.mode == opt_pkg::MODE_ONESHOT && trigger) begin
          nxt_q.cnt = q_ff.reload;
          nxt_q.st = opt_pkg::ST_ONESHOT;
          nxt_q.pulse = 1'b1;
        end else if (PWM_OK && q_ff.start && q_ff.mode == opt_pkg::MODE_PWM &&
                     (!q_ff.trig_sel || trig_ovf_i)) begin
          // start with a rising edge, so the value is loaded now
          nxt_q.cnt = q_ff.reload;
          nxt_q.sub = 8'h00;
          nxt_q.cyc = 16'h0000;
          nxt_q.pulse = (n_new != 16'h0000);
          nxt_q.st = opt_pkg::ST_PWM;
        end
      end
      // one pass of n count periods
      opt_pkg::ST_ONESHOT: begin
        if (!q_ff.start || q_ff.mode != opt_pkg::MODE_ONESHOT) begin
          nxt_q.st = opt_pkg::ST_IDLE;
          nxt_q.pulse = 1'b0;
        end else if (trigger) begin
          nxt_q.cnt = q_ff.reload;
        end else if (tick) begin
          if (q_ff.cnt <= 16'h0001) begin
            // zero reached: reload, halt and request service
            nxt_q.cnt = q_ff.reload;
            nxt_q.st = opt_pkg::ST_IDLE;
            nxt_q.pulse = 1'b0;
            nxt_q.irq = 1'b1;
          end else begin
            nxt_q.cnt = q_ff.cnt - 16'h0001;
          end
        end
      end
      // continuous modulation; triggers are not looked at here
      opt_pkg::ST_PWM: begin
        if (!q_ff.start || q_ff.mode != opt_pkg::MODE_PWM) begin
          nxt_q.st = opt_pkg::ST_IDLE;
          nxt_q.pulse = 1'b0;
        end else if (tick) begin
          if (q_ff.sub == m_cur) begin
            nxt_q.sub = 8'h00;
            nxt_q.cyc = cyc_nx;
            if (cyc_nx == 16'h0000) begin
              // rising edge of the cycle takes the new value
              nxt_q.cnt = q_ff.reload;
              nxt_q.pulse = (n_new != 16'h0000);
            end else if (q_ff.pulse && cyc_nx == n_cur) begin
              nxt_q.pulse = 1'b0;
              nxt_q.irq = 1'b1;
            end
          end else begin
            nxt_q.sub = q_ff.sub + 8'h01;
          end
        end
      end
      default: begin
        nxt_q.st = opt_pkg::ST_IDLE;
        nxt_q.pulse = 1'b0;
      end
    endcase

    // pin function: modulation forces the pulse, otherwise configurable
    if (PWM_OK && q_ff.mode == opt_pkg::MODE_PWM) begin
      nxt_q.pin = nxt_q.pulse;
    end else begin
      nxt_q.pin = q_ff.pulse_out ? nxt_q.pulse : q_ff.port_bit;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  // the whole channel freezes while the clock enable is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_ff.mode <= opt_pkg::MODE_TIMER;
      q_ff.cks <= opt_pkg::CKS_F1;
      q_ff.pwm8 <= 1'b0;
      q_ff.pulse_out <= 1'b0;
      q_ff.port_bit <= 1'b0;
      q_ff.trig_sel <= 1'b0;
      q_ff.start <= 1'b0;
      q_ff.reload <= opt_pkg::RELOAD_RST;
      q_ff.cnt <= opt_pkg::RELOAD_RST;
      q_ff.sub <= 8'h00;
      q_ff.cyc <= 16'h0000;
      q_ff.pulse <= 1'b0;
      q_ff.irq <= 1'b0;
      q_ff.pin <= 1'b0;
      q_ff.st <= opt_pkg::ST_IDLE;
    end else if (ce_i) begin
      q_ff <= nxt_q;
    end
  end

  // outputs straight from flip-flops
  assign channel_pulse_pin_o = q_ff.pin;
  assign irq_req_o = q_ff.irq;

endmodule

// ### opt_timer_channel_props.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// port checker for the timer channel
// ------------------------------------------------------------
module opt_timer_channel_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [opt_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic trig_ovf_i,
  input wire logic channel_pulse_pin_o,
  input wire logic irq_req_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] mode_ff; // shadow of the mode byte
  logic [1:0] age_ff; // cycles since a mode write, saturating
  logic wr; // acked write with the low byte
  logic rd; // acked read
  logic mwr; // mode write lands
  logic swr0; // start flag cleared
  logic shown; // pin follows the pulse
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
  assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && wb_ack_o;
  assign mwr = wr && wb_adr_i == opt_pkg::OFS_MODE;
  assign swr0 = wr && wb_adr_i == opt_pkg::OFS_START && !wb_dat_i[0];
  assign shown = mode_ff[1:0] == 2'h3 || (mode_ff[1:0] == 2'h2 && mode_ff[5]);
  // the age lets the pin settle before mode-based checks apply
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_ff <= 8'h00;
      age_ff <= 2'h0;
    end else if (mwr) begin
      mode_ff <= wb_dat_i[7:0];
      age_ff <= 2'h0;
    end else if (age_ff != 2'h3) begin
      age_ff <= age_ff + 2'h1;
    end
  end
  chk_ack_one_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not given one cycle after request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
    else $error("ack without request");
  chk_timer_read_undef: assert property (
    rd && wb_adr_i == opt_pkg::OFS_TIMER |-> wb_dat_o == 32'h0000FFFF)
    else $error("timer read shows a live value");
  chk_unmapped_zero: assert property (rd && wb_adr_i == 5'h14 |-> wb_dat_o == 32'h00000000)
    else $error("unmapped read not zero");
  chk_irq_on_fall: assert property (
    irq_req_o && shown && age_ff == 2'h3 |-> $fell(channel_pulse_pin_o))
    else $error("interrupt without pulse fall");
  chk_irq_one_cycle: assert property (irq_req_o |=> !irq_req_o)
    else $error("interrupt longer than one cycle");
  chk_port_bit_pin: assert property (
    mode_ff[1:0] == 2'h2 && !mode_ff[5] && age_ff == 2'h3 |-> channel_pulse_pin_o == mode_ff[6])
    else $error("port bit not on pin");
  chk_stop_pin_low: assert property (swr0 && shown |-> ##2 !channel_pulse_pin_o [*3])
    else $error("pin still pulsing after stop");
  chk_idle_mode_quiet: assert property (mode_ff[1:0] < 2'h2 && age_ff == 2'h3 |-> !irq_req_o)
    else $error("interrupt in an idle mode");
  cover property (irq_req_o && mode_ff[1:0] == 2'h3);
  cover property (irq_req_o && mode_ff[1:0] == 2'h2);
  cover property (swr0 && shown);
endmodule

// ### opt_pin_partner.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// far side: another timer's overflow and a pin watcher
// ------------------------------------------------------------
module opt_pin_partner (
  input wire logic clk_i,
  input wire logic pin_i,
  output logic trig_o
);
  int cyc_n = 0; // free cycle count
  int rise_t = 0; // cycle of the last rise
  int high_w = 0; // last high width in cycles
  int period = 0; // last rise-to-rise distance
  int rises = 0; // rises seen
  logic last = 1'b0; // pin one cycle ago
  initial begin
    trig_o = 1'b0;
  end
  // edges are timed on the sampling clock, so widths are exact
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    last <= pin_i;
    if (pin_i === 1'b1 && last === 1'b0) begin
      period <= cyc_n - rise_t;
      rise_t <= cyc_n;
      rises <= rises + 1;
    end
    if (pin_i === 1'b0 && last === 1'b1) begin
      high_w <= cyc_n - rise_t;
    end
  end
  // one-cycle overflow pulse, launched just after an edge
  task automatic fire();
    trig_o <= 1'b1;
    @(posedge clk_i);
    trig_o <= 1'b0;
  endtask
endmodule

// ### opt_timer_channel_tb.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// bench: register-level scenarios for a pulse-pin channel
// ------------------------------------------------------------
module opt_timer_channel_tb;
  logic clk_i = 1'b0; // 100 MHz
  logic rst_i = 1'b1; // held 12 cycles
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [4:0] wb_adr_i = 5'h00;
  logic [3:0] wb_sel_i = 4'hF; // whole words only
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic trig; // overflow from the partner
  logic pin; // pulse pin
  logic irq; // interrupt request
  logic [31:0] rd; // last read data
  int bad_count = 0;
  int comparisons = 0;
  int irqs = 0; // interrupt pulses seen
  int k; // scratch rise count
  int base; // scratch interrupt count
  int dv; // expected clock divider
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  opt_timer_channel #(.CHANNEL_ID(2)) dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .trig_ovf_i(trig), .channel_pulse_pin_o(pin), .irq_req_o(irq));
  opt_pin_partner p (.clk_i(clk_i), .pin_i(pin), .trig_o(trig));
  // count interrupt pulses
  always @(posedge clk_i) begin
    if (irq === 1'b1) begin
      irqs <= irqs + 1;
    end
  end
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one classic cycle; ack is awaited, never assumed
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) begin
      check("bus ack", 32'h0, 32'h1);
      finish_test();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // bounded wait on the interrupt count (0) or the rise count (1)
  task automatic wait_for(input bit on_rise, input int goal);
    int n;
    n = 0;
    while ((on_rise ? p.rises : irqs) < goal && n < 30000) begin
      @(posedge clk_i);
      n++;
    end
    if ((on_rise ? p.rises : irqs) < goal) begin
      check("wait bound", 32'h0, 32'h1);
      finish_test();
    end
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(0, opt_pkg::OFS_MODE, 32'h0);
    check("mode reset", rd, 32'h0);
    bus(0, 5'h14, 32'h0);
    check("unmapped read", rd, 32'h0);
    // one-shot on the undivided clock, reload 3 loaded while stopped
    bus(1, opt_pkg::OFS_MODE, 32'h22);
    bus(1, opt_pkg::OFS_TIMER, 32'h3);
    bus(1, opt_pkg::OFS_START, 32'h1);
    for (int i = 1; i <= 2; i++) begin
      bus(1, opt_pkg::OFS_ONESHOT, 32'h1);
      wait_for(0, i);
      check("one-shot width", p.high_w, 32'd3);
    end
    bus(0, opt_pkg::OFS_STATUS, 32'h0);
    check("halted after pass", rd, 32'h0);
    bus(0, opt_pkg::OFS_TIMER, 32'h0);
    check("timer read", rd, 32'h0000FFFF);
    // a write during a pass only reaches the reload
    bus(1, opt_pkg::OFS_TIMER, 32'd40);
    bus(1, opt_pkg::OFS_ONESHOT, 32'h1);
    bus(1, opt_pkg::OFS_TIMER, 32'd5);
    wait_for(0, 3);
    check("pass keeps count", p.high_w, 32'd40);
    bus(1, opt_pkg::OFS_ONESHOT, 32'h1);
    wait_for(0, 4);
    check("next pass reload", p.high_w, 32'd5);
    // overflow trigger, then a retrigger five cycles later
    bus(1, opt_pkg::OFS_MODE, 32'hA2);
    bus(1, opt_pkg::OFS_TIMER, 32'd10);
    p.fire();
    repeat (4) @(posedge clk_i);
    p.fire();
    wait_for(0, 5);
    check("retrigger width", p.high_w, 32'd15);
    // clear the start flag mid-pass
    bus(1, opt_pkg::OFS_TIMER, 32'd100);
    p.fire();
    repeat (5) @(posedge clk_i);
    bus(1, opt_pkg::OFS_START, 32'h0);
    repeat (120) @(posedge clk_i);
    check("stopped pin", pin, 32'h0);
    check("no extra irq", irqs, 32'd5);
    // pin as a plain port bit
    bus(1, opt_pkg::OFS_MODE, 32'h42);
    repeat (3) @(posedge clk_i);
    check("port bit high", pin, 32'h1);
    bus(1, opt_pkg::OFS_MODE, 32'h02);
    repeat (3) @(posedge clk_i);
    check("port bit low", pin, 32'h0);
    // timer and event codes leave the channel idle
    for (int m = 0; m < 2; m++) begin
      bus(1, opt_pkg::OFS_MODE, 32'h20 | 32'(m));
      bus(1, opt_pkg::OFS_START, 32'h1);
      bus(1, opt_pkg::OFS_ONESHOT, 32'h1);
      bus(0, opt_pkg::OFS_STATUS, 32'h0);
      check("idle mode", rd, 32'h0);
      bus(1, opt_pkg::OFS_START, 32'h0);
    end
    // 8-bit modulation started by overflow, n=3 m=1, port bit set
    bus(1, opt_pkg::OFS_MODE, 32'hD3);
    bus(1, opt_pkg::OFS_TIMER, 32'h0301);
    bus(1, opt_pkg::OFS_START, 32'h1);
    repeat (20) @(posedge clk_i);
    check("waits for trigger", pin, 32'h0);
    k = p.rises;
    p.fire();
    wait_for(1, k + 1);
    base = irqs;
    repeat (100) @(posedge clk_i);
    p.fire();
    wait_for(1, k + 2);
    check("pwm8 period", p.period, 32'd510);
    check("pwm8 high", p.high_w, 32'd6);
    check("irq per fall", irqs - base, 32'd1);
    bus(0, opt_pkg::OFS_TIMER, 32'h0);
    check("timer read pwm", rd, 32'h0000FFFF);
    // divided count clocks, codes 1 to 3, n=1 m=0
    for (int c = 1; c < 4; c++) begin
      dv = (c == 1) ? opt_pkg::DIV8 : opt_pkg::DIV32;
      bus(1, opt_pkg::OFS_START, 32'h0);
      bus(1, opt_pkg::OFS_MODE, 32'h13 | 32'(c << 2));
      bus(1, opt_pkg::OFS_TIMER, 32'h0100);
      bus(1, opt_pkg::OFS_START, 32'h1);
      k = p.rises;
      // the first step after start has an arbitrary prescaler phase, so
      // only the second full cycle gives exact period and width
      wait_for(1, k + 3);
      check("divided period", p.period, 32'(255 * dv));
      check("divided high", p.high_w, 32'(dv));
    end
    // 16-bit modulation, n=4
    bus(1, opt_pkg::OFS_START, 32'h0);
    bus(1, opt_pkg::OFS_MODE, 32'h03);
    bus(1, opt_pkg::OFS_TIMER, 32'd4);
    bus(1, opt_pkg::OFS_START, 32'h1);
    base = irqs;
    wait_for(0, base + 1);
    check("pwm16 high", p.high_w, 32'd4);
    finish_test();
  end
endmodule
bind opt_timer_channel opt_timer_channel_props props (.clk_i(clk_i), .rst_i(rst_i),
  .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .trig_ovf_i(trig_ovf_i),
  .channel_pulse_pin_o(channel_pulse_pin_o), .irq_req_o(irq_req_o));
